// File: core/drr_remote_reply.sv
`timescale 1ns/1ns
`default_nettype none
module drr_remote_reply
  import drr_pkg::*;
#(
  parameter int SLOTS = DRR_EXT_SLOTS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  monitor_command_flag,
  input  wire logic                  freq_write_volatile_flag,
  input  wire logic                  freq_write_nonvolatile_flag,
  input  wire logic                  instruction_execute_flag,
  input  wire logic [15:0]           monitor_code_word,
  input  wire logic [3:0][15:0]      extra_monitor_code,
  input  wire logic [15:0]           instruction_code_word,
  input  wire logic [SLOTS-1:0][15:0] ext_instruction_code,
  input  wire logic [7:0]            fault_history_select,
  input  wire logic [15:0]           speed_display_setting,
  input  wire logic [15:0]           reply_format_setting,
  input  wire logic                  net_mode,
  input  wire logic                  running,
  input  wire logic                  freq_in_range,
  input  wire logic [SLOTS:0]        code_known,
  input  wire logic [SLOTS:0]        data_in_range,
  input  wire logic [SLOTS:0][15:0]  read_value,
  input  wire logic [15:0]           out_freq,
  input  wire logic [15:0]           set_freq,
  input  wire logic [15:0]           out_current,
  input  wire logic [15:0]           out_voltage,
  input  wire logic                  fault_log_valid,
  input  wire logic [7:0]            fault_log_code,
  input  wire logic [15:0]           fault_log_freq,
  input  wire logic [15:0]           fault_log_current,
  input  wire logic [15:0]           fault_log_voltage,
  input  wire logic [15:0]           fault_log_time,
  output logic      [15:0]           first_monitor_value,
  output logic      [15:0]           second_monitor_value,
  output logic      [15:0]           reply_code_word,
  output logic      [15:0]           instruction_read_data,
  output logic      [3:0][15:0]      extra_monitor_value,
  output logic      [15:0]           fault_record_code,
  output logic      [15:0]           fault_record_frequency,
  output logic      [15:0]           fault_record_current,
  output logic      [15:0]           fault_record_voltage,
  output logic      [15:0]           fault_record_energized_time,
  output logic      [SLOTS-1:0][15:0] ext_reply_code,
  output logic      [SLOTS-1:0][15:0] ext_read_data
);
  localparam int FW = 72;

  logic        freq_flag_prev;
  logic        exec_flag_prev;
  logic        freq_event;
  logic        exec_event;
  logic        split_format;
  logic [7:0]  freq_result;
  logic [7:0]  instr_result;
  logic [31:0] out_speed_wide;
  logic [31:0] set_speed_wide;
  logic [15:0] out_freq_shown;
  logic [15:0] set_freq_shown;
  logic [DRR_FAULT_AW-1:0] fault_wr_ptr;
  logic [DRR_FAULT_AW-1:0] fault_rd_addr;
  logic [FW-1:0]           fault_wr_data;
  logic [FW-1:0]           fault_rd_data;
  logic [7:0]              fault_sel_q;
  logic                    fault_sel_valid;

  // ********************************************
  // Request edges
  // ********************************************
  // Flags are levels held by the master; only the rising edge starts a request so a held flag
  // does not keep rewriting the reply.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      freq_flag_prev <= 1'b0;
      exec_flag_prev <= 1'b0;
    end else begin
      freq_flag_prev <= freq_write_volatile_flag | freq_write_nonvolatile_flag;
      exec_flag_prev <= instruction_execute_flag;
    end
  end

  assign freq_event   = (freq_write_volatile_flag | freq_write_nonvolatile_flag) & ~freq_flag_prev;
  assign exec_event   = instruction_execute_flag & ~exec_flag_prev;
  assign split_format = reply_format_setting != 16'h0000;

  // ********************************************
  // Speed display conversion
  // ********************************************
  // The setting is the machine speed at the reference frequency, so the product is divided back
  // by the reference in hundredths of a hertz.
  assign out_speed_wide = (32'(out_freq) * 32'(speed_display_setting)) / 32'(DRR_SPEED_DIV);
  assign set_speed_wide = (32'(set_freq) * 32'(speed_display_setting)) / 32'(DRR_SPEED_DIV);

  always_comb begin
    if (speed_display_setting != 16'h0000) begin
      out_freq_shown = out_speed_wide[15:0];
      set_freq_shown = set_speed_wide[15:0];
    end else begin
      out_freq_shown = out_freq;
      set_freq_shown = set_freq;
    end
  end

  function automatic logic [15:0] monitor_pick(input logic [7:0] code);
    logic [15:0] value;
    value = 16'h0000;
    unique case (code)
      DRR_MON_OUT_FREQ: value = out_freq_shown;
      DRR_MON_SET_FREQ: value = set_freq_shown;
      DRR_MON_CURRENT:  value = out_current;
      DRR_MON_VOLTAGE:  value = out_voltage;
      default:          value = 16'h0000;
    endcase
    return value;
  endfunction

  // ********************************************
  // Monitor values
  // ********************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      first_monitor_value <= DRR_RESET_WORD;
    end else if (monitor_command_flag) begin
      first_monitor_value <= monitor_pick(monitor_code_word[7:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      second_monitor_value <= DRR_RESET_WORD;
    end else if (monitor_code_word[15:8] == DRR_MON_NONE) begin
      second_monitor_value <= out_freq_shown;
    end else if (monitor_command_flag) begin
      second_monitor_value <= monitor_pick(monitor_code_word[15:8]);
    end
  end

  for (genvar m = 0; m < 4; m++) begin : g_extra_mon
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        extra_monitor_value[m] <= DRR_RESET_WORD;
      end else if (monitor_command_flag) begin
        extra_monitor_value[m] <= monitor_pick(extra_monitor_code[m][7:0]);
      end
    end
  end

  // ********************************************
  // Frequency setting reply
  // ********************************************
  always_comb begin
    if (!net_mode) begin
      freq_result = DRR_REPLY_MODE;
    end else if (!freq_in_range) begin
      freq_result = DRR_REPLY_RANGE;
    end else begin
      freq_result = DRR_REPLY_OK;
    end
  end

  // ********************************************
  // Instruction slots
  // ********************************************
  drr_reply_slot u_slot_main (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .exec          (exec_event),
    .code_word     (instruction_code_word),
    .net_mode      (net_mode),
    .running       (running),
    .code_known    (code_known[0]),
    .data_in_range (data_in_range[0]),
    .read_value    (read_value[0]),
    .result        (instr_result),
    .reply         (),
    .rdata         (instruction_read_data)
  );

  for (genvar s = 0; s < SLOTS; s++) begin : g_ext_slot
    drr_reply_slot u_slot (
      .clk_sys       (clk_sys),
      .resetn        (resetn),
      .exec          (exec_event),
      .code_word     (ext_instruction_code[s]),
      .net_mode      (net_mode),
      .running       (running),
      .code_known    (code_known[s+1]),
      .data_in_range (data_in_range[s+1]),
      .read_value    (read_value[s+1]),
      .result        (),
      .reply         (ext_reply_code[s]),
      .rdata         (ext_read_data[s])
    );
  end

  // ********************************************
  // Shared reply word
  // ********************************************
  // In the full-width format a frequency and an instruction request on the same edge cannot both
  // be shown; the instruction reply is kept.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reply_code_word <= DRR_RESET_WORD;
    end else if (split_format) begin
      if (freq_event) begin
        reply_code_word[7:0] <= freq_result;
      end
      if (exec_event) begin
        reply_code_word[15:8] <= instr_result;
      end
    end else if (exec_event) begin
      reply_code_word <= {8'h00, instr_result};
    end else if (freq_event) begin
      reply_code_word <= {8'h00, freq_result};
    end
  end

  // ********************************************
  // Fault history
  // ********************************************
  // Newest entry sits just behind the write pointer, so history number zero is the latest fault.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_wr_ptr <= '0;
    end else if (fault_log_valid) begin
      fault_wr_ptr <= fault_wr_ptr + 1'b1;
    end
  end

  assign fault_wr_data = {fault_log_code, fault_log_freq, fault_log_current, fault_log_voltage, fault_log_time};
  assign fault_rd_addr = fault_wr_ptr - 1'b1 - fault_history_select[DRR_FAULT_AW-1:0];

  drr_fault_memory #(
    .WIDTH (FW)
  ) u_fault_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wr_en   (fault_log_valid),
    .wr_addr (fault_wr_ptr),
    .wr_data (fault_wr_data),
    .rd_addr (fault_rd_addr),
    .rd_data (fault_rd_data)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_sel_q     <= 8'h00;
      fault_sel_valid <= 1'b0;
    end else begin
      fault_sel_q     <= fault_history_select;
      fault_sel_valid <= fault_history_select < 8'(DRR_FAULT_DEPTH);
    end
  end

  // A history number beyond the stored depth reads back as empty records with the number echoed.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_record_code           <= DRR_RESET_WORD;
      fault_record_frequency      <= DRR_RESET_WORD;
      fault_record_current        <= DRR_RESET_WORD;
      fault_record_voltage        <= DRR_RESET_WORD;
      fault_record_energized_time <= DRR_RESET_WORD;
    end else if (fault_sel_valid) begin
      fault_record_code           <= {fault_sel_q, fault_rd_data[71:64]};
      fault_record_frequency      <= fault_rd_data[63:48];
      fault_record_current        <= fault_rd_data[47:32];
      fault_record_voltage        <= fault_rd_data[31:16];
      fault_record_energized_time <= fault_rd_data[15:0];
    end else begin
      fault_record_code           <= {fault_sel_q, 8'h00};
      fault_record_frequency      <= DRR_RESET_WORD;
      fault_record_current        <= DRR_RESET_WORD;
      fault_record_voltage        <= DRR_RESET_WORD;
      fault_record_energized_time <= DRR_RESET_WORD;
    end
  end
endmodule
`default_nettype wire

// File: core/drr_pkg.sv
// How it works
// - First monitor follows low code byte
// - Upper byte zero shows output frequency
// - Nonzero upper byte selects second monitor
// - Speed display converts frequency monitors
// - Format zero shares reply word
// - Zero reply success, nonzero failure
// - Split format: low frequency, high instruction
// - Successful read instruction loads paired read data
// - Monitors three to six follow codes
// - Fault code low, history number high
// - Fault frequency, current, voltage, time
// - Extended slots reply on execute
// - Word replies zero to three
// - Instruction write while running networked fails
// - Frequency reply 00, 01, 03
// - Instruction reply 00 to 03
package drr_pkg;
  localparam logic [7:0]  DRR_MON_NONE     = 8'h00;
  localparam logic [7:0]  DRR_MON_OUT_FREQ = 8'h01;
  localparam logic [7:0]  DRR_MON_CURRENT  = 8'h02;
  localparam logic [7:0]  DRR_MON_VOLTAGE  = 8'h03;
  localparam logic [7:0]  DRR_MON_SET_FREQ = 8'h05;
  localparam logic [7:0]  DRR_REPLY_OK     = 8'h00;
  localparam logic [7:0]  DRR_REPLY_MODE   = 8'h01;
  localparam logic [7:0]  DRR_REPLY_SELECT = 8'h02;
  localparam logic [7:0]  DRR_REPLY_RANGE  = 8'h03;
  localparam int          DRR_WRITE_BIT    = 7;
  localparam int          DRR_SPEED_DIV    = 6000;
  localparam int          DRR_FAULT_DEPTH  = 8;
  localparam int          DRR_FAULT_AW     = 3;
  localparam int          DRR_EXT_SLOTS    = 5;
  localparam logic [15:0] DRR_RESET_WORD   = 16'h0000;
endpackage

// File: core/drr_reply_slot.sv
`timescale 1ns/1ns
`default_nettype none
module drr_reply_slot
  import drr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        exec,
  input  wire logic [15:0] code_word,
  input  wire logic        net_mode,
  input  wire logic        running,
  input  wire logic        code_known,
  input  wire logic        data_in_range,
  input  wire logic [15:0] read_value,
  output logic      [7:0]  result,
  output logic      [15:0] reply,
  output logic      [15:0] rdata
);
  logic is_write;

  assign is_write = code_word[DRR_WRITE_BIT];

  // ********************************************
  // Result code, checks in priority order
  // ********************************************
  always_comb begin
    if (is_write && net_mode && running) begin
      result = DRR_REPLY_MODE;
    end else if (!code_known) begin
      result = DRR_REPLY_SELECT;
    end else if (is_write && !data_in_range) begin
      result = DRR_REPLY_RANGE;
    end else begin
      result = DRR_REPLY_OK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reply <= DRR_RESET_WORD;
    end else if (exec) begin
      reply <= {8'h00, result};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= DRR_RESET_WORD;
    end else if (exec && result == DRR_REPLY_OK && !is_write) begin
      rdata <= read_value;
    end
  end
endmodule
`default_nettype wire

// File: core/drr_fault_memory.sv
`timescale 1ns/1ns
`default_nettype none
module drr_fault_memory
  import drr_pkg::*;
#(
  parameter int WIDTH = 72,
  parameter int DEPTH = DRR_FAULT_DEPTH,
  parameter int AW    = DRR_FAULT_AW
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Entries are not cleared at reset; unwritten slots read as whatever the array holds.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// File: bench/drr_remote_reply_properties.sv
`timescale 1ns/1ns
`default_nettype none
module drr_remote_reply_properties
  import drr_pkg::*;
#(
  parameter int SLOTS = DRR_EXT_SLOTS
) (
  input wire logic             clk_sys,
  input wire logic             resetn,
  input wire logic             monitor_command_flag,
  input wire logic             freq_write_volatile_flag,
  input wire logic             freq_write_nonvolatile_flag,
  input wire logic             instruction_execute_flag,
  input wire logic [15:0]      monitor_code_word,
  input wire logic [3:0][15:0] extra_monitor_code,
  input wire logic [15:0]      instruction_code_word,
  input wire logic [7:0]       fault_history_select,
  input wire logic [15:0]      speed_display_setting,
  input wire logic [15:0]      reply_format_setting,
  input wire logic             net_mode,
  input wire logic             running,
  input wire logic             freq_in_range,
  input wire logic [SLOTS:0]   code_known,
  input wire logic [SLOTS:0]   data_in_range,
  input wire logic [15:0]      out_freq,
  input wire logic [15:0]      out_current,
  input wire logic [15:0]      first_monitor_value,
  input wire logic [15:0]      second_monitor_value,
  input wire logic [15:0]      reply_code_word,
  input wire logic [3:0][15:0] extra_monitor_value,
  input wire logic [15:0]      fault_record_code
);
  // ******
  // Checks
  // ******
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic       fq;
  logic [7:0] fr0;
  logic [7:0] ir0;
  assign fq  = freq_write_volatile_flag || freq_write_nonvolatile_flag;
  assign fr0 = !net_mode ? 8'h01 : !freq_in_range ? 8'h03 : 8'h00;
  assign ir0 = (instruction_code_word[7] && net_mode && running) ? 8'h01 : !code_known[0] ? 8'h02 :
               (instruction_code_word[7] && !data_in_range[0]) ? 8'h03 : 8'h00;
  function automatic logic [15:0] shown(logic [15:0] f, logic [15:0] s);
    return (s == 16'h0000) ? f : 16'((32'(f) * 32'(s)) / DRR_SPEED_DIV);
  endfunction
  property p_first_mon;
    monitor_command_flag && monitor_code_word[7:0] == 8'h02 |=> first_monitor_value == $past(out_current);
  endproperty
  a_first_mon: assert property (p_first_mon) else $error("first monitor wrong");
  property p_speed;
    monitor_command_flag && monitor_code_word[7:0] == 8'h01 |=>
      first_monitor_value == shown($past(out_freq), $past(speed_display_setting));
  endproperty
  a_speed: assert property (p_speed) else $error("speed monitor wrong");
  property p_second_freq;
    monitor_code_word[15:8] == 8'h00 |=>
      second_monitor_value == shown($past(out_freq), $past(speed_display_setting));
  endproperty
  a_second_freq: assert property (p_second_freq) else $error("second monitor wrong");
  property p_extra;
    monitor_command_flag && extra_monitor_code[3][7:0] == 8'h02 |=> extra_monitor_value[3] == $past(out_current);
  endproperty
  a_extra: assert property (p_extra) else $error("sixth monitor wrong");
  // The record lags the select by a memory read, so only a settled select is judged.
  property p_fault_echo;
    $stable(fault_history_select) [*4] |-> fault_record_code[15:8] == fault_history_select;
  endproperty
  a_fault_echo: assert property (p_fault_echo) else $error("history number not echoed");
  property p_freq_reply;
    $rose(fq) && !$rose(instruction_execute_flag) |=> reply_code_word == (($past(reply_format_setting) == 16'h0000) ?
      {8'h00, $past(fr0)} : {$past(reply_code_word[15:8]), $past(fr0)});
  endproperty
  a_freq_reply: assert property (p_freq_reply) else $error("frequency reply wrong");
  property p_instr_split;
    $rose(instruction_execute_flag) && reply_format_setting != 16'h0000 |=> reply_code_word[15:8] == $past(ir0);
  endproperty
  a_instr_split: assert property (p_instr_split) else $error("instruction reply wrong");
  property p_hold;
    !$rose(fq) && !$rose(instruction_execute_flag) |=> $stable(reply_code_word);
  endproperty
  a_hold: assert property (p_hold) else $error("reply changed without request");
  c_freq: cover property ($rose(fq));
  c_instr: cover property ($rose(instruction_execute_flag) && reply_format_setting != 16'h0000);
  c_speed: cover property (monitor_command_flag && speed_display_setting != 16'h0000);
endmodule
bind drr_remote_reply drr_remote_reply_properties #(.SLOTS(SLOTS)) i_props (.*);
`default_nettype wire

// File: bench/drr_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module drr_master_model (
  input  wire logic        clk_sys,
  input  wire logic [1:0]  hold_cyc,
  input  wire logic [15:0] reply_code_word,
  output var  logic        monitor_command_flag,
  output var  logic        freq_write_volatile_flag,
  output var  logic        freq_write_nonvolatile_flag,
  output var  logic        instruction_execute_flag
);
  // ************
  // Polling side
  // ************
  initial begin
    monitor_command_flag = 1'b0;
    freq_write_volatile_flag = 1'b0;
    freq_write_nonvolatile_flag = 1'b0;
    instruction_execute_flag = 1'b0;
  end
  task automatic mon(input logic on);
    monitor_command_flag = on;
  endtask
  // Requests are edges, so each flag drops for a full cycle before it may rise again.
  task automatic request(input logic [1:0] kind, output logic [15:0] rep);
    @(negedge clk_sys);
    freq_write_volatile_flag = (kind == 2'h0);
    freq_write_nonvolatile_flag = (kind == 2'h1);
    instruction_execute_flag = (kind == 2'h2);
    repeat (32'(hold_cyc) + 1) @(negedge clk_sys);
    rep = reply_code_word;
    freq_write_volatile_flag = 1'b0;
    freq_write_nonvolatile_flag = 1'b0;
    instruction_execute_flag = 1'b0;
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_drive_remote_reply_registers.sv
`timescale 1ns/1ns
`default_nettype none
module tb_drive_remote_reply_registers;
  import drr_pkg::*;
  localparam int S = DRR_EXT_SLOTS;
  localparam logic [7:0] CODES [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h04};
  logic               clk_sys, resetn, net_mode, running, freq_in_range, fault_log_valid;
  logic               monitor_command_flag, freq_write_volatile_flag, freq_write_nonvolatile_flag;
  logic               instruction_execute_flag;
  logic [1:0]         hold_cyc;
  logic [7:0]         fault_history_select, fault_log_code, r;
  logic [15:0]        monitor_code_word, instruction_code_word, speed_display_setting, reply_format_setting;
  logic [15:0]        out_freq, set_freq, out_current, out_voltage, fault_log_freq, fault_log_current;
  logic [15:0]        fault_log_voltage, fault_log_time, first_monitor_value, second_monitor_value;
  logic [15:0]        reply_code_word, instruction_read_data, fault_record_code, fault_record_frequency;
  logic [15:0]        fault_record_current, fault_record_voltage, fault_record_energized_time;
  logic [15:0]        seed, got, prev, exp_rd;
  logic [3:0][15:0]   extra_monitor_code, extra_monitor_value;
  logic [S-1:0][15:0] ext_instruction_code, ext_reply_code, ext_read_data, exp_xrd;
  logic [S:0]         code_known, data_in_range;
  logic [S:0][15:0]   read_value;
  logic [71:0]        flog [3];
  int                 failures, num_checks;
  drr_remote_reply #(.SLOTS(S)) i_dut (.*);
  drr_master_model i_master (.*);
  // *******
  // Helpers
  // *******
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [15:0] shown(logic [15:0] f);
    return (speed_display_setting == 16'h0000) ? f : 16'((32'(f) * 32'(speed_display_setting)) / DRR_SPEED_DIV);
  endfunction
  function automatic logic [15:0] mon(logic [7:0] c);
    case (c)
      8'h01: return shown(out_freq);
      8'h02: return out_current;
      8'h03: return out_voltage;
      8'h05: return shown(set_freq);
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [7:0] ires(logic w, int s);
    if (w && net_mode && running) return 8'h01;
    if (!code_known[s]) return 8'h02;
    if (w && !data_in_range[s]) return 8'h03;
    return 8'h00;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic shake();
    {out_freq, set_freq, out_current, out_voltage} = {rnd(), rnd(), rnd(), rnd()};
    {monitor_code_word, instruction_code_word} = {rnd(), rnd()};
    {speed_display_setting, reply_format_setting} = {rnd(), rnd()};
    {fault_log_freq, fault_log_current, fault_log_voltage, fault_log_time} = {rnd(), rnd(), rnd(), rnd()};
    extra_monitor_code = {rnd(), rnd(), rnd(), rnd()};
    {fault_log_code, fault_history_select} = rnd();
    got = rnd();
    {code_known, data_in_range} = got[2*S+1:0];
    {net_mode, running, freq_in_range} = got[15:13];
    for (int j = 0; j <= S; j++) begin
      read_value[j] = rnd();
      if (j < S) ext_instruction_code[j] = rnd();
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
  initial begin
    seed = 16'h0037;
    {resetn, fault_log_valid, hold_cyc, exp_rd, exp_xrd} = '0;
    failures = 0;
    num_checks = 0;
    shake();
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    chk(reply_code_word, 16'h0000);
    chk(instruction_read_data, 16'h0000);
    $display("reset test done");
    i_master.mon(1'b1);
    for (int i = 0; i < 12; i++) begin
      shake();
      if (i < 6) speed_display_setting = 16'h0000;
      monitor_code_word = {CODES[(i + 2) % 6], CODES[i % 6]};
      for (int j = 0; j < 4; j++) extra_monitor_code[j] = {8'h00, CODES[(i + j) % 6]};
      @(negedge clk_sys);
      chk(first_monitor_value, mon(monitor_code_word[7:0]));
      got = (monitor_code_word[15:8] == 8'h00) ? shown(out_freq) : mon(monitor_code_word[15:8]);
      chk(second_monitor_value, got);
      for (int j = 0; j < 4; j++) chk(extra_monitor_value[j], mon(extra_monitor_code[j][7:0]));
    end
    i_master.mon(1'b0);
    prev = first_monitor_value;
    shake();
    monitor_code_word[15:8] = 8'h00;
    @(negedge clk_sys);
    chk(first_monitor_value, prev);
    chk(second_monitor_value, shown(out_freq));
    $display("monitor test done");
    for (int i = 0; i < 8; i++) begin
      reply_format_setting = {15'h0000, i[2]};
      {net_mode, freq_in_range} = i[1:0];
      hold_cyc = 2'(i);
      prev = reply_code_word;
      i_master.request(2'(i % 2), got);
      r = !net_mode ? 8'h01 : !freq_in_range ? 8'h03 : 8'h00;
      chk(got, (i < 4) ? {8'h00, r} : {prev[15:8], r});
    end
    $display("frequency reply test done");
    for (int i = 0; i < 16; i++) begin
      shake();
      reply_format_setting = {15'h0000, i[0]};
      hold_cyc = 2'(i);
      prev = reply_code_word;
      i_master.request(2'h2, got);
      r = ires(instruction_code_word[7], 0);
      chk(got, i[0] ? {r, prev[7:0]} : {8'h00, r});
      if (r == 8'h00 && !instruction_code_word[7]) exp_rd = read_value[0];
      chk(instruction_read_data, exp_rd);
      for (int s = 0; s < S; s++) begin
        r = ires(ext_instruction_code[s][7], s + 1);
        if (r == 8'h00 && !ext_instruction_code[s][7]) exp_xrd[s] = read_value[s+1];
        chk(ext_reply_code[s], {8'h00, r});
        chk(ext_read_data[s], exp_xrd[s]);
      end
      if (i[0]) begin
        prev = reply_code_word;
        i_master.request(2'(i[1]), got);
        r = !net_mode ? 8'h01 : !freq_in_range ? 8'h03 : 8'h00;
        chk(got, {prev[15:8], r});
        chk(instruction_read_data, exp_rd);
      end
    end
    $display("instruction reply test done");
    for (int k = 0; k < 3; k++) begin
      shake();
      flog[k] = {fault_log_code, fault_log_freq, fault_log_current, fault_log_voltage, fault_log_time};
      fault_log_valid = 1'b1;
      @(negedge clk_sys);
      fault_log_valid = 1'b0;
      @(negedge clk_sys);
    end
    for (int k = 0; k < 3; k++) begin
      fault_history_select = 8'(k);
      repeat (3) @(negedge clk_sys);
      chk(fault_record_code, {8'(k), flog[2-k][71:64]});
      chk(fault_record_frequency, flog[2-k][63:48]);
      chk(fault_record_current, flog[2-k][47:32]);
      chk(fault_record_voltage, flog[2-k][31:16]);
      chk(fault_record_energized_time, flog[2-k][15:0]);
    end
    fault_history_select = 8'h09;
    repeat (3) @(negedge clk_sys);
    chk(fault_record_code, 16'h0900);
    $display("fault record test done");
    complete_run();
  end
endmodule
`default_nettype wire
